/* rtl/twr_pkg.sv */
// shared constants and types of the two-wire register access port
package twr_pkg;
    localparam logic [6:0] TARGET_ADDR  = 7'h36; // fixed, no strap
    localparam logic [7:0] WR_LIMIT     = 8'h4F; // last auto-increment write
    localparam logic [7:0] FUNCTION_COMMAND_BYTE_ADDR    = 8'hFE; // function_command_byte slot
    localparam logic [7:0] PAST_END     = 8'hFF; // read value past the end
    localparam logic [7:0] MEAS_FIRST   = 8'h08; // first measurement byte
    localparam logic [7:0] MEAS_LAST    = 8'h0F; // last measurement byte
    localparam logic [7:0] PAIR_LAST    = 8'h10; // last two-byte msb
    localparam logic [7:0] CFG_ADDR     = 8'h01;
    localparam logic [7:0] ACR_MSB_ADDR = 8'h10;
    localparam logic [7:0] ACR_LSB_ADDR = 8'h11;
    localparam logic [7:0] OBIAS_ADDR   = 8'h61;
    localparam logic [7:0] ABIAS_ADDR   = 8'h62;
    localparam logic [7:0] MEM_RST      = 8'h00; // shadow reset value
    localparam int         CLK_NS       = 40;    // 25 MHz clock period
    localparam int         SPIKE_NS     = 50;    // glitch width to reject
    // least time, rounded up to whole cycles
    localparam int         FILT_CYC     = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] FILT_CNT     = 3'(FILT_CYC);

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h2,
        ST_MEMORY_ADDRESS_BYTE     = 4'h3,
        ST_MEMORY_ADDRESS_BYTE_ACK = 4'h4,
        ST_WDATA     = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA     = 4'h7,
        ST_RACK      = 4'h8
    } state_t;

    // one accepted write byte on its way to the shadow memory
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } wr_req_t;

    // live measurement values, msb byte at the even address
    typedef struct packed {
        logic [15:0] aux0;
        logic [15:0] aux1;
        logic [15:0] volt;
        logic [15:0] curr;
    } meas_t;
endpackage : twr_pkg

/* rtl/twr_mem.sv */
// shadow register memory, one write port, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module twr_mem
    import twr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       we_i,
    input  wire logic [7:0] waddr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] raddr_i,
    output logic      [7:0] rdata_a_o,
    output logic      [7:0] rdata_b_o
);
    logic [7:0] mem_q [256];

    // working copy only; no nonvolatile store behind it
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            for (int i = 0; i < 256; i++)
                mem_q[i] <= MEM_RST;
        end
        else if (we_i)
        begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // port b reads the odd partner of the addressed byte
    always_ff @(posedge clk_i)
    begin
        rdata_a_o <= mem_q[raddr_i];
        rdata_b_o <= mem_q[{raddr_i[7:1], 1'b1}];
    end
endmodule : twr_mem
`default_nettype wire

/* rtl/twr_buf.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module twr_buf #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);
    logic [W-1:0] slot1_q;
    logic         v1_q;
    logic         pop;
    logic         push;

    // full means the second slot holds a word
    assign in_ready_o = ~v1_q;
    assign pop        = out_valid_o & out_ready_i;
    assign push       = in_valid_i & ~v1_q;

    // head slot drives the output straight from its flops
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            out_valid_o <= 1'b0;
            v1_q        <= 1'b0;
            out_data_o  <= '0;
            slot1_q     <= '0;
        end
        else if (pop && v1_q)
        begin
            out_data_o <= slot1_q;
            v1_q       <= 1'b0;
        end
        else if (pop)
        begin
            out_valid_o <= push;
            out_data_o  <= in_data_i;
        end
        else if (push && !out_valid_o)
        begin
            out_valid_o <= 1'b1;
            out_data_o  <= in_data_i;
        end
        else if (push)
        begin
            v1_q    <= 1'b1;
            slot1_q <= in_data_i;
        end
    end
endmodule : twr_buf
`default_nettype wire

/* rtl/two_wire_register_access_slave.sv */
// two-wire target port giving byte access to the register memory
//
// What this block does
// - direction bit zero writes, one reads
// - works up to 400kHz, no speed setting
// - address-only probe gets acknowledged
// - every byte acknowledged before the next, except a write byte while the buffer is full
// - write: address, pointer byte, data bytes
// - master drives line except acknowledge cycles
// - device drives line from read-address acknowledge
// - master not-acknowledge releases line to master
// - pointer advances at each written byte lsb
// - auto-increment writes past 4Fh dropped
// - read-only, reserved and FEh writes dropped
// - partial or unacknowledged bytes never stored
// - writes touch only the shadow copy
// - reads msb first, pointer advances after lsb
// - reads past FFh return FFh
// - reserved addresses may read any value
// - answers only target address 0110110
// - two-byte register pair held during read
`timescale 1ns/1ps
`default_nettype none
module two_wire_register_access_slave (
    input  wire logic            clk_i,
    input  wire logic            srst_i,
    input  wire logic            scl_i,
    input  wire logic            sda_i,
    output logic                 sda_o,
    output logic                 sda_oe_o,
    input  wire twr_pkg::meas_t  meas_i,
    output logic                 wr_valid_o,
    input  wire logic            wr_ready_i,
    output twr_pkg::wr_req_t     wr_req_o
);
    import twr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [1:0]  sync1_q;   // index 0 clock line, 1 data line
    logic [1:0]  sync2_q;
    logic [1:0]  filt_q;
    logic [2:0]  cnt_q [2];
    logic        scl_p_q;
    logic        sda_p_q;
    logic        scl_f;
    logic        sda_f;
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;

    state_t      state_q;
    state_t      state_d;
    logic [7:0]  shreg_q;
    logic [7:0]  shreg_d;
    logic [3:0]  bits_q;
    logic [3:0]  bits_d;
    logic [8:0]  ptr_q;     // bit 8 set once past the last address
    logic [8:0]  ptr_d;
    logic [8:0]  ptr_inc;
    logic        rw_q;
    logic        rw_d;
    logic        mack_q;
    logic        mack_d;
    logic        oe_q;
    logic        oe_d;
    logic        first_q;   // next data byte is the directly addressed one
    logic        first_d;
    logic [8:0]  wa_q;      // address captured at the lsb of a write byte
    logic [8:0]  wa_d;
    logic        wfirst_q;
    logic        wfirst_d;
    logic        hold_v_q;
    logic        hold_v_d;
    logic [7:0]  hold_a_q;
    logic [7:0]  hold_a_d;
    logic [7:0]  hold_b_q;
    logic [7:0]  hold_b_d;

    logic        load;
    logic        push;
    logic        buf_ready;
    logic [7:0]  mem_a;
    logic [7:0]  mem_b;
    logic [7:0]  live_byte;
    logic [7:0]  lsb_byte;
    logic [7:0]  rd_byte;
    logic        pair_msb;
    logic        wr_ok;
    wr_req_t     push_req;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // byte k of the measurement block, k zero at the first address
    function automatic logic [7:0] meas_byte(input logic [63:0] v,
                                             input logic [2:0]  k);
        logic [63:0] t;
        t = v >> {3'd7 - k, 3'b000};
        return t[7:0];
    endfunction : meas_byte

    function automatic logic in_meas(input logic [7:0] a);
        return (a >= MEAS_FIRST) && (a <= MEAS_LAST);
    endfunction : in_meas

    // only these locations take data from the bus
    function automatic logic writable(input logic [7:0] a);
        return (a == CFG_ADDR) || (a == ACR_MSB_ADDR) || (a == ACR_LSB_ADDR)
            || (a == OBIAS_ADDR) || (a == ABIAS_ADDR);
    endfunction : writable

    ////////////////////////////////////////////////////////////////////////
    // line sampling

    // two flops against metastability, only the second flop reads the first
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
        end
        else
        begin
            sync1_q <= {sda_i, scl_i};
            sync2_q <= sync1_q;
        end
    end

    // a level must stand a full spike width before it is believed
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            filt_q   <= 2'h3;
            cnt_q[0] <= 3'h0;
            cnt_q[1] <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (sync2_q[i] == filt_q[i])
                    cnt_q[i] <= 3'h0;
                else if (cnt_q[i] >= FILT_CNT)
                begin
                    filt_q[i] <= sync2_q[i];
                    cnt_q[i]  <= 3'h0;
                end
                else
                    cnt_q[i] <= cnt_q[i] + 3'h1;
            end
        end
    end

    // previous filtered levels for edge detection
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= filt_q[0];
            sda_p_q <= filt_q[1];
        end
    end

    // oversampling at 25 MHz covers any bus rate up to 400 kHz
    assign scl_f = filt_q[0];
    assign sda_f = filt_q[1];
    assign rise  = scl_f & ~scl_p_q;
    assign fall  = ~scl_f & scl_p_q;
    assign start = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop  = scl_f & scl_p_q & ~sda_p_q & sda_f;

    ////////////////////////////////////////////////////////////////////////
    // read data selection

    // saturate so a long read keeps reporting the past-end value
    assign ptr_inc  = ptr_q[8] ? ptr_q : ptr_q + 9'h001;
    assign pair_msb = ~ptr_q[8] && ~ptr_q[0] && (ptr_q[7:0] >= MEAS_FIRST)
                      && (ptr_q[7:0] <= PAIR_LAST);

    // reserved locations simply return whatever the shadow holds
    always_comb
    begin
        if (in_meas(ptr_q[7:0]))
            live_byte = meas_byte(meas_i, 3'(ptr_q[7:0] - MEAS_FIRST));
        else
            live_byte = mem_a;
        if (in_meas({ptr_q[7:1], 1'b1}))
            lsb_byte = meas_byte(meas_i, 3'({ptr_q[7:1], 1'b1} - MEAS_FIRST));
        else
            lsb_byte = mem_b;
        if (ptr_q[8])
            rd_byte = PAST_END;
        else if (hold_v_q && (ptr_q[7:0] == hold_a_q))
            rd_byte = hold_b_q;
        else
            rd_byte = live_byte;
    end

    // dropped writes are acknowledged unless the buffer is full, they just go nowhere
    assign wr_ok = ~wa_q[8] && writable(wa_q[7:0])
                   && (wfirst_q || (wa_q[7:0] <= WR_LIMIT))
                   && (wfirst_q || (wa_q[7:0] != FUNCTION_COMMAND_BYTE_ADDR));
    assign push_req.addr = wa_q[7:0];
    assign push_req.data = shreg_q;

    ////////////////////////////////////////////////////////////////////////
    // bit engine

    always_comb
    begin
        state_d  = state_q;
        shreg_d  = shreg_q;
        bits_d   = bits_q;
        ptr_d    = ptr_q;
        rw_d     = rw_q;
        mack_d   = mack_q;
        oe_d     = oe_q;
        first_d  = first_q;
        wa_d     = wa_q;
        wfirst_d = wfirst_q;
        hold_v_d = hold_v_q;
        hold_a_d = hold_a_q;
        hold_b_d = hold_b_q;
        load     = 1'b0;
        push     = 1'b0;
        if (start)
        begin
            state_d  = ST_ADDR;
            bits_d   = 4'h0;
            oe_d     = 1'b0;
            hold_v_d = 1'b0;
        end
        else if (stop)
        begin
            state_d  = ST_IDLE;
            oe_d     = 1'b0;
            hold_v_d = 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE: ;
                ST_ADDR:
                begin
                    if (rise)
                    begin
                        shreg_d = {shreg_q[6:0], sda_f};
                        bits_d  = bits_q + 4'h1;
                    end
                    else if (fall && (bits_q == 4'h8))
                    begin
                        if (shreg_q[7:1] == TARGET_ADDR)
                        begin
                            oe_d    = 1'b1;
                            rw_d    = shreg_q[0];
                            state_d = ST_ADDR_ACK;
                        end
                        else
                            state_d = ST_IDLE;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (fall && rw_q)
                        load = 1'b1;
                    else if (fall)
                    begin
                        oe_d    = 1'b0;
                        bits_d  = 4'h0;
                        state_d = ST_MEMORY_ADDRESS_BYTE;
                    end
                end
                ST_MEMORY_ADDRESS_BYTE:
                begin
                    if (rise)
                    begin
                        shreg_d = {shreg_q[6:0], sda_f};
                        bits_d  = bits_q + 4'h1;
                    end
                    else if (fall && (bits_q == 4'h8))
                    begin
                        ptr_d   = {1'b0, shreg_q};
                        first_d = 1'b1;
                        oe_d    = 1'b1;
                        state_d = ST_MEMORY_ADDRESS_BYTE_ACK;
                    end
                end
                ST_MEMORY_ADDRESS_BYTE_ACK:
                begin
                    if (fall)
                    begin
                        oe_d    = 1'b0;
                        bits_d  = 4'h0;
                        state_d = ST_WDATA;
                    end
                end
                ST_WDATA:
                begin
                    if (rise)
                    begin
                        shreg_d = {shreg_q[6:0], sda_f};
                        bits_d  = bits_q + 4'h1;
                        if (bits_q == 4'h7)
                        begin
                            wa_d     = ptr_q;
                            wfirst_d = first_q;
                            first_d  = 1'b0;
                            ptr_d    = ptr_inc;
                        end
                    end
                    else if (fall && (bits_q == 4'h8))
                    begin
                        // a full buffer answers not-acknowledge, byte lost
                        oe_d    = buf_ready;
                        push    = buf_ready && wr_ok;
                        state_d = ST_WDATA_ACK;
                    end
                end
                ST_WDATA_ACK:
                begin
                    if (fall)
                    begin
                        oe_d    = 1'b0;
                        bits_d  = 4'h0;
                        state_d = ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    if (fall && (bits_q == 4'h8))
                    begin
                        oe_d    = 1'b0;
                        ptr_d   = ptr_inc;
                        state_d = ST_RACK;
                    end
                    else if (fall)
                    begin
                        oe_d    = ~shreg_q[6];
                        shreg_d = {shreg_q[6:0], 1'b1};
                        bits_d  = bits_q + 4'h1;
                    end
                end
                ST_RACK:
                begin
                    if (rise)
                        mack_d = ~sda_f;
                    else if (fall && mack_q)
                        load = 1'b1;
                    else if (fall)
                    begin
                        oe_d    = 1'b0;
                        state_d = ST_IDLE;
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
        // next outgoing byte, first bit driven at once
        if (load)
        begin
            shreg_d = rd_byte;
            oe_d    = ~rd_byte[7];
            bits_d  = 4'h1;
            state_d = ST_RDATA;
            if (pair_msb)
            begin
                hold_v_d = 1'b1;
                hold_a_d = {ptr_q[7:1], 1'b1};
                hold_b_d = lsb_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers

    // transfer sequencing
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_q <= ST_IDLE;
            shreg_q <= 8'h00;
            bits_q  <= 4'h0;
            rw_q    <= 1'b0;
            mack_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            shreg_q <= shreg_d;
            bits_q  <= bits_d;
            rw_q    <= rw_d;
            mack_q  <= mack_d;
        end
    end

    // memory pointer and write address capture
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ptr_q    <= 9'h000;
            first_q  <= 1'b0;
            wa_q     <= 9'h000;
            wfirst_q <= 1'b0;
        end
        else
        begin
            ptr_q    <= ptr_d;
            first_q  <= first_d;
            wa_q     <= wa_d;
            wfirst_q <= wfirst_d;
        end
    end

    // pair hold, cleared by any start or stop
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            hold_v_q <= 1'b0;
            hold_a_q <= 8'h00;
            hold_b_q <= 8'h00;
        end
        else
        begin
            hold_v_q <= hold_v_d;
            hold_a_q <= hold_a_d;
            hold_b_q <= hold_b_d;
        end
    end

    // open drain: only ever pulls low, changes while the clock is low
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            oe_q  <= 1'b0;
            sda_o <= 1'b0;
        end
        else
        begin
            oe_q  <= oe_d;
            sda_o <= 1'b0;
        end
    end
    assign sda_oe_o = oe_q;

    ////////////////////////////////////////////////////////////////////////
    // write path and shadow memory

    twr_buf #(
        .W ($bits(wr_req_t))
    ) u_buf (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (push),
        .in_ready_o  (buf_ready),
        .in_data_i   (push_req),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (wr_req_o)
    );

    // shadow written only when the consumer takes the word
    twr_mem u_mem (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .we_i      (wr_valid_o & wr_ready_i),
        .waddr_i   (wr_req_o.addr),
        .wdata_i   (wr_req_o.data),
        .raddr_i   (ptr_q[7:0]),
        .rdata_a_o (mem_a),
        .rdata_b_o (mem_b)
    );
endmodule : two_wire_register_access_slave
`default_nettype wire

/* bench/twr_props.sv */
// property checker for the two-wire register access port
`timescale 1ns/1ps
`default_nettype none
module twr_props (
    input wire logic             clk_i,
    input wire logic             srst_i,
    input wire logic             scl_i,
    input wire logic             sda_i,
    input wire logic             sda_o,
    input wire logic             sda_oe_o,
    input wire twr_pkg::meas_t   meas_i,
    input wire logic             wr_valid_o,
    input wire logic             wr_ready_i,
    input wire twr_pkg::wr_req_t wr_req_o
);
    import twr_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////
    AST_SDA_LOW: assert property (sda_o == 1'b0)
        else $error("data output not low");
    // the pin may only move while the bus clock is low
    AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("drive moved with clock high");
    AST_OE_HOLD: assert property ($rose(sda_oe_o) |=> sda_oe_o[*8])
        else $error("drive dropped early");
    AST_BUF_HOLD: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable(wr_req_o))
        else $error("write word lost in stall");
    AST_WR_ADDR: assert property (wr_valid_o |-> wr_req_o.addr inside
        {8'h01, 8'h10, 8'h11, 8'h61, 8'h62})
        else $error("write to a protected place");
    AST_PUSH_LOW: assert property ($rose(wr_valid_o) |-> !scl_i)
        else $error("write word outside ack");
    AST_RST: assert property (disable iff (1'b0) srst_i |=>
        !sda_oe_o && !wr_valid_o && wr_req_o == '0)
        else $error("outputs not cleared by reset");
    AST_WAKE: assert property (disable iff (1'b0)
        $fell(srst_i) |-> (!sda_oe_o)[*4])
        else $error("drive right after reset");
    // main scenarios
    cover property ($rose(sda_oe_o));
    cover property (wr_valid_o && wr_ready_i);
    cover property (wr_valid_o && !wr_ready_i ##1 wr_valid_o);
endmodule : twr_props
`default_nettype wire

/* bench/twr_master.sv */
// behavioural two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module twr_master #(
    parameter int H = 32 // 68-clock bit keeps the rate below 400kHz
) (
    input  wire logic clk_i,
    input  wire logic sda_w_i,
    output logic      scl_o,
    output logic      sda_lo_o
);
    // idle bus: clock high, data left to the pull-up
    initial
    begin
        scl_o    = 1'b1;
        sda_lo_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    // data falls with clock high, also as repeated start
    task automatic start;
        sda_lo_o <= 1'b0;
        tick(H);
        scl_o <= 1'b1;
        tick(H);
        sda_lo_o <= 1'b1;
        tick(H);
        scl_o <= 1'b0;
        tick(4);
    endtask : start
    // data rises with clock high
    task automatic stop;
        sda_lo_o <= 1'b1;
        tick(H);
        scl_o <= 1'b1;
        tick(H);
        sda_lo_o <= 1'b0;
        tick(H);
    endtask : stop
    // data set while clock low, held a little past the fall
    task automatic bit_io(input logic b, output logic r);
        sda_lo_o <= !b;
        tick(H);
        scl_o <= 1'b1;
        tick(H);
        r = sda_w_i;
        scl_o <= 1'b0;
        tick(4);
    endtask : bit_io
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wbyte
    task automatic rbyte(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nak, r);
    endtask : rbyte
endmodule : twr_master
`default_nettype wire

/* bench/tb_two_wire_register_access_slave.sv */
// self-checking bench for the two-wire register access port
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_register_access_slave;
    import twr_pkg::*;
    localparam int LIMIT = 60000; // about three times the planned traffic
    logic    clk, srst, scl, m_lo, sda_w, sda_o, sda_oe, wr_valid, wr_ready;
    meas_t   meas;
    wr_req_t wr_req;
    int      bad_count, compares, cyc;
    // pull-up unless a party pulls low
    assign sda_w = !(m_lo || (sda_oe && !sda_o));
    two_wire_register_access_slave i_two_wire_register_access_slave (
        .clk_i(clk), .srst_i(srst), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .meas_i(meas),
        .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_req_o(wr_req));
    twr_master i_twr_master (.clk_i(clk), .sda_w_i(sda_w), .scl_o(scl), .sda_lo_o(m_lo));
    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] d, input logic e);
        logic a;
        i_twr_master.wbyte(d, a);
        chk(16'(e), 16'(a));
    endtask : wr
    task automatic rd(input logic nak, input logic [7:0] e);
        logic [7:0] d;
        i_twr_master.rbyte(nak, d);
        chk(16'(e), 16'(d));
    endtask : rd
    // pointer write then repeated start in read direction
    task automatic rd_open(input logic [7:0] p);
        i_twr_master.start();
        wr(8'h6C, 1'b1);
        wr(p, 1'b1);
        i_twr_master.start();
        wr(8'h6D, 1'b1);
    endtask : rd_open
    ////////////////////////////////////////////////////////////////
    task automatic t_probe;
        i_twr_master.start();
        wr(8'h6C, 1'b1);
        i_twr_master.stop();
        i_twr_master.start();
        wr(8'h6E, 1'b0);
        i_twr_master.stop();
        $display("test probe done");
    endtask : t_probe
    // consumer stalled: auto-increment, dropped bytes, full buffer refuses
    task automatic t_write;
        i_twr_master.start();
        wr(8'h6C, 1'b1);
        wr(8'h10, 1'b1);
        wr(8'hA5, 1'b1);
        wr(8'h5A, 1'b1);
        wr(8'h3C, 1'b0);
        i_twr_master.stop();
        chk(16'h10A5, wr_req);
        @(posedge clk);
        wr_ready <= 1'b1;
        @(posedge clk);
        wr_ready <= 1'b0;
        #1 chk(16'h115A, wr_req);
        @(posedge clk);
        wr_ready <= 1'b1;
        @(posedge clk);
        wr_ready <= 1'b0;
        #1 chk(16'h0, 16'(wr_valid));
        i_twr_master.start();
        wr(8'h6C, 1'b1);
        wr(8'h61, 1'b1);
        wr(8'h77, 1'b1);
        wr(8'h88, 1'b1);
        wr(8'h99, 1'b1);
        i_twr_master.stop();
        chk(16'h6177, wr_req);
        @(posedge clk);
        wr_ready <= 1'b1;
        @(posedge clk);
        #1 chk(16'h0, 16'(wr_valid));
        $display("test write done");
    endtask : t_write
    task automatic t_read;
        rd_open(8'h61);
        rd(1'b0, 8'h77);
        rd(1'b1, 8'h00);
        i_twr_master.stop();
        chk(16'h0, 16'(sda_oe));
        $display("test read done");
    endtask : t_read
    // value changes mid msb byte; the lsb must come from the latch
    task automatic t_pair;
        @(posedge clk);
        meas.volt <= 16'h1234;
        rd_open(8'h0C);
        fork
            rd(1'b0, 8'h12);
            begin
                repeat (300) @(posedge clk);
                meas.volt <= 16'hABCD;
            end
        join
        rd(1'b1, 8'h34);
        i_twr_master.stop();
        $display("test pair done");
    endtask : t_pair
    task automatic t_end;
        logic [7:0] d;
        rd_open(8'hFE);
        i_twr_master.rbyte(1'b0, d);
        i_twr_master.rbyte(1'b0, d);
        rd(1'b0, 8'hFF);
        rd(1'b1, 8'hFF);
        i_twr_master.stop();
        $display("test end done");
    endtask : t_end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        wr_ready = 1'b0;
        meas = '0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (8) @(posedge clk);
        t_probe();
        t_write();
        t_read();
        t_pair();
        t_end();
        close_out();
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            bad_count++;
            close_out();
        end
    end
endmodule : tb_two_wire_register_access_slave
bind two_wire_register_access_slave twr_props i_twr_props (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .meas_i(meas_i),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_req_o(wr_req_o));
`default_nettype wire
